/* File: tpg_pkg.sv */
`default_nettype none

//==========================================================
// Function
// - reset leaves every pin plain I/O; 01 selects alternate
// - power-saving mode freezes pin direction and level
// - three independent ports, each with own registers
// - pin n select field at bits 4n+1:4n
// - port 0 alternates: spi, pwm, uart handshake
// - port 1 alternates: uart data, pwm sync/trip/outputs
// - port 2 alternates pwm; gpio feeds interrupts, clock
// - direction bits 31:24, one means output
// - output levels bits 23:16 drive output pins
// - bits 15:8 read pin levels seen at reset
// - bits 7:0 read current sampled pin levels
// - set register ones set output bits
// - clear register ones clear output bits
// - port 0 pin 2 pull-up always on
// - lock bit blocks select and direction/data writes
// - pull-up off bit one disables pull-up
package tpg_pkg;

    localparam int NPORT = 3;
    localparam int NBIT = 8;

    // register byte addresses, one entry per port
    localparam logic [31:0] ADDR_FSEL [NPORT] =
        '{32'hFFFF0D00, 32'hFFFF0D04, 32'hFFFF0D08};
    localparam logic [31:0] ADDR_DAT [NPORT] =
        '{32'hFFFF0D20, 32'hFFFF0D30, 32'hFFFF0D40};
    localparam logic [31:0] ADDR_SET [NPORT] =
        '{32'hFFFF0D24, 32'hFFFF0D34, 32'hFFFF0D44};
    localparam logic [31:0] ADDR_CLR [NPORT] =
        '{32'hFFFF0D28, 32'hFFFF0D38, 32'hFFFF0D48};
    localparam logic [31:0] ADDR_PAR [NPORT] =
        '{32'hFFFF0D2C, 32'hFFFF0D3C, 32'hFFFF0D4C};

    // direction/data field positions
    localparam int DIR_LSB = 24;
    localparam int DOUT_LSB = 16;
    localparam int RSTLVL_LSB = 8;
    localparam int SMP_LSB = 0;

    // parameter register field positions
    localparam int LOCK_LSB = 16;
    localparam int DRV_LSB = 8;
    localparam int PUOFF_LSB = 0;

    // function select layout and codes
    localparam int FSEL_STRIDE = 4;
    localparam int FSEL_W = 2;
    localparam logic [1:0] FSEL_GPIO = 2'h0;
    localparam logic [1:0] FSEL_ALT = 2'h1;
    localparam logic [31:0] FSEL_MASK = 32'h03333333;

    // reset values
    localparam logic [31:0] RST_FSEL = 32'h00000000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h00000000;

    // pins that own an alternate function, per port
    localparam logic [7:0] ALT_MASK [NPORT] = '{8'h7F, 8'h7F, 8'h03};
    // pull-ups that cannot be switched off, per port
    localparam logic [7:0] PU_FORCED [NPORT] = '{8'h04, 8'h00, 8'h00};

    // pins feeding external interrupt and clock inputs
    localparam int EXTINT0_PIN = 4;
    localparam int EXTINT1_PIN = 0;
    localparam int EXTINT2_PIN = 0;
    localparam int EXTINT3_PIN = 1;
    localparam int EXT_CLK_PIN = 0;

endpackage

`default_nettype wire

/* File: tpg_gpio.sv */
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module tpg_gpio
(
    input wire logic sys_clk, // system clock, 100 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic [31:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    input wire logic power_save, // chip in power-saving mode
    input wire logic [7:0] pin_in_p0, // port 0 pin levels
    input wire logic [7:0] pin_in_p1, // port 1 pin levels
    input wire logic [7:0] pin_in_p2, // port 2 pin levels
    output logic [7:0] pin_out_p0, // port 0 pin drive level
    output logic [7:0] pin_out_p1, // port 1 pin drive level
    output logic [7:0] pin_out_p2, // port 2 pin drive level
    output logic [7:0] pin_oe_p0, // port 0 drive enable
    output logic [7:0] pin_oe_p1, // port 1 drive enable
    output logic [7:0] pin_oe_p2, // port 2 drive enable
    output logic [7:0] pullup_en_p0, // port 0 pull-up enable
    output logic [7:0] pullup_en_p1, // port 1 pull-up enable
    output logic [7:0] pullup_en_p2, // port 2 pull-up enable
    output logic [7:0] drive_strength_p0, // port 0 high drive
    output logic [7:0] drive_strength_p1, // port 1 high drive
    output logic [7:0] drive_strength_p2, // port 2 high drive
    input wire logic [7:0] alt_out_p0, // port 0 peripheral levels
    input wire logic [7:0] alt_out_p1, // port 1 peripheral levels
    input wire logic [7:0] alt_out_p2, // port 2 peripheral levels
    input wire logic [7:0] alt_oe_p0, // port 0 peripheral enables
    input wire logic [7:0] alt_oe_p1, // port 1 peripheral enables
    input wire logic [7:0] alt_oe_p2, // port 2 peripheral enables
    output logic [7:0] alt_in_p0, // port 0 levels to peripherals
    output logic [7:0] alt_in_p1, // port 1 levels to peripherals
    output logic [7:0] alt_in_p2, // port 2 levels to peripherals
    output logic [7:0] alt_sel_p0, // port 0 pins in alternate mode
    output logic [7:0] alt_sel_p1, // port 1 pins in alternate mode
    output logic [7:0] alt_sel_p2, // port 2 pins in alternate mode
    output logic external_interrupt_in_0, // port 0 pin 4 level
    output logic external_interrupt_in_1, // port 1 pin 0 level
    output logic external_interrupt_in_2, // port 2 pin 0 level
    output logic external_interrupt_in_3, // port 2 pin 1 level
    output logic external_clock_input // port 2 pin 0 level
);

    //======================================================
    // per-port storage and pin-side views
    logic [31:0] fsel [tpg_pkg::NPORT];
    logic [7:0] dir [tpg_pkg::NPORT];
    logic [7:0] dout [tpg_pkg::NPORT];
    logic [7:0] lock [tpg_pkg::NPORT];
    logic [7:0] drv [tpg_pkg::NPORT];
    logic [7:0] puoff [tpg_pkg::NPORT];
    logic [7:0] smp [tpg_pkg::NPORT];
    logic [7:0] rstlvl [tpg_pkg::NPORT];
    logic [7:0] pin_in [tpg_pkg::NPORT];
    logic [7:0] alt_out [tpg_pkg::NPORT];
    logic [7:0] alt_oe [tpg_pkg::NPORT];
    logic [7:0] alt_sel [tpg_pkg::NPORT];
    logic [7:0] gpio_sel [tpg_pkg::NPORT];
    logic [7:0] pout [tpg_pkg::NPORT];
    logic [7:0] poe [tpg_pkg::NPORT];
    logic [7:0] pu [tpg_pkg::NPORT];
    logic [7:0] ain [tpg_pkg::NPORT];
    logic [31:0] lockm [tpg_pkg::NPORT];
    logic captured;
    logic [31:0] next_rdata;

    //======================================================
    // flatten separate port vectors into arrays
    assign pin_in[0] = pin_in_p0;
    assign pin_in[1] = pin_in_p1;
    assign pin_in[2] = pin_in_p2;
    assign alt_out[0] = alt_out_p0;
    assign alt_out[1] = alt_out_p1;
    assign alt_out[2] = alt_out_p2;
    assign alt_oe[0] = alt_oe_p0;
    assign alt_oe[1] = alt_oe_p1;
    assign alt_oe[2] = alt_oe_p2;

    // outputs come straight from flops
    assign pin_out_p0 = pout[0];
    assign pin_out_p1 = pout[1];
    assign pin_out_p2 = pout[2];
    assign pin_oe_p0 = poe[0];
    assign pin_oe_p1 = poe[1];
    assign pin_oe_p2 = poe[2];
    assign pullup_en_p0 = pu[0];
    assign pullup_en_p1 = pu[1];
    assign pullup_en_p2 = pu[2];
    assign drive_strength_p0 = drv[0];
    assign drive_strength_p1 = drv[1];
    assign drive_strength_p2 = drv[2];
    assign alt_in_p0 = ain[0];
    assign alt_in_p1 = ain[1];
    assign alt_in_p2 = ain[2];

    // mode view is decoded from the select flops
    assign alt_sel_p0 = alt_sel[0];
    assign alt_sel_p1 = alt_sel[1];
    assign alt_sel_p2 = alt_sel[2];

    //======================================================
    // reset-level capture
    // pins are caught on the first edge after release, since an
    // async reset may only load constants
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            captured <= 1'b0;
        else
            captured <= 1'b1;
    end

    //======================================================
    // one slice per port
    for (genvar p = 0; p < tpg_pkg::NPORT; p++)
    begin : g_port
        logic hit_fsel;
        logic hit_dat;
        logic hit_set;
        logic hit_clr;
        logic hit_par;
        logic [7:0] wdir;
        logic [7:0] wout;

        // each port decodes its own five addresses
        assign hit_fsel = reg_wr && reg_addr == tpg_pkg::ADDR_FSEL[p];
        assign hit_dat = reg_wr && reg_addr == tpg_pkg::ADDR_DAT[p];
        assign hit_set = reg_wr && reg_addr == tpg_pkg::ADDR_SET[p];
        assign hit_clr = reg_wr && reg_addr == tpg_pkg::ADDR_CLR[p];
        assign hit_par = reg_wr && reg_addr == tpg_pkg::ADDR_PAR[p];
        assign wdir = reg_wdata[tpg_pkg::DIR_LSB +: tpg_pkg::NBIT];
        assign wout = reg_wdata[tpg_pkg::DOUT_LSB +: tpg_pkg::NBIT];

        // per pin: lock mask on select field, mode decode
        for (genvar n = 0; n < tpg_pkg::NBIT; n++)
        begin : g_pin
            logic [1:0] code;
            assign code = fsel[p][tpg_pkg::FSEL_STRIDE*n +: tpg_pkg::FSEL_W];
            assign lockm[p][tpg_pkg::FSEL_STRIDE*n +: tpg_pkg::FSEL_STRIDE] =
                {2'h0, {2{lock[p][n]}}};
            // only 01 on a pin that owns an alternate leaves gpio
            assign alt_sel[p][n] = code == tpg_pkg::FSEL_ALT
                && tpg_pkg::ALT_MASK[p][n];
            assign gpio_sel[p][n] = !alt_sel[p][n];
        end

        // function select: locked and reserved fields keep value
        always_ff @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
                fsel[p] <= tpg_pkg::RST_FSEL;
            else if (hit_fsel)
                fsel[p] <= (fsel[p] & lockm[p])
                    | (reg_wdata & tpg_pkg::FSEL_MASK & ~lockm[p]);
        end

        // direction bits, blocked per pin by lock
        always_ff @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
                dir[p] <= tpg_pkg::RST_BYTE;
            else if (hit_dat)
                dir[p] <= (dir[p] & lock[p]) | (wdir & ~lock[p]);
        end

        // output levels: direct write, set and clear
        // set/clear honour the lock too, as they alter the same bits
        always_ff @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
                dout[p] <= tpg_pkg::RST_BYTE;
            else if (hit_dat)
                dout[p] <= (dout[p] & lock[p]) | (wout & ~lock[p]);
            else if (hit_set)
                dout[p] <= dout[p] | (wout & ~lock[p]);
            else if (hit_clr)
                dout[p] <= dout[p] & ~(wout & ~lock[p]);
        end

        // parameter register: lock, drive strength, pull-up off
        always_ff @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                lock[p] <= tpg_pkg::RST_BYTE;
                drv[p] <= tpg_pkg::RST_BYTE;
                puoff[p] <= tpg_pkg::RST_BYTE;
            end
            else if (hit_par)
            begin
                lock[p] <= reg_wdata[tpg_pkg::LOCK_LSB +: tpg_pkg::NBIT];
                drv[p] <= reg_wdata[tpg_pkg::DRV_LSB +: tpg_pkg::NBIT];
                puoff[p] <= reg_wdata[tpg_pkg::PUOFF_LSB +: tpg_pkg::NBIT];
            end
        end

        // pull-up control; port 0 pin 2 is hard-wired on
        always_ff @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
                pu[p] <= ~tpg_pkg::RST_BYTE;
            else
                pu[p] <= ~puoff[p] | tpg_pkg::PU_FORCED[p];
        end

        // input sampling every cycle
        always_ff @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
                smp[p] <= tpg_pkg::RST_BYTE;
            else
                smp[p] <= pin_in[p];
        end

        // levels seen right after reset, held until next reset
        always_ff @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
                rstlvl[p] <= tpg_pkg::RST_BYTE;
            else if (!captured)
                rstlvl[p] <= pin_in[p];
        end

        // pin drive mux; frozen while the chip sleeps
        always_ff @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                pout[p] <= tpg_pkg::RST_BYTE;
                poe[p] <= tpg_pkg::RST_BYTE;
            end
            else if (!power_save)
            begin
                pout[p] <= (alt_sel[p] & alt_out[p])
                    | (gpio_sel[p] & dout[p]);
                poe[p] <= (alt_sel[p] & alt_oe[p])
                    | (gpio_sel[p] & dir[p]);
            end
        end

        // pin levels passed to peripherals only in alternate mode
        always_ff @(posedge sys_clk or negedge rst_b)
        begin
            if (!rst_b)
                ain[p] <= tpg_pkg::RST_BYTE;
            else
                ain[p] <= pin_in[p] & alt_sel[p];
        end
    end

    //======================================================
    // interrupt and clock feeds, gpio mode only
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            external_interrupt_in_0 <= 1'b0;
            external_interrupt_in_1 <= 1'b0;
            external_interrupt_in_2 <= 1'b0;
            external_interrupt_in_3 <= 1'b0;
            external_clock_input <= 1'b0;
        end
        else
        begin
            external_interrupt_in_0 <= pin_in[0][tpg_pkg::EXTINT0_PIN]
                & gpio_sel[0][tpg_pkg::EXTINT0_PIN];
            external_interrupt_in_1 <= pin_in[1][tpg_pkg::EXTINT1_PIN]
                & gpio_sel[1][tpg_pkg::EXTINT1_PIN];
            external_interrupt_in_2 <= pin_in[2][tpg_pkg::EXTINT2_PIN]
                & gpio_sel[2][tpg_pkg::EXTINT2_PIN];
            external_interrupt_in_3 <= pin_in[2][tpg_pkg::EXTINT3_PIN]
                & gpio_sel[2][tpg_pkg::EXTINT3_PIN];
            external_clock_input <= pin_in[2][tpg_pkg::EXT_CLK_PIN]
                & gpio_sel[2][tpg_pkg::EXT_CLK_PIN];
        end
    end

    //======================================================
    // read mux; set, clear and unmapped addresses give zero
    always_comb
    begin
        next_rdata = tpg_pkg::RD_ZERO;
        for (int p = 0; p < tpg_pkg::NPORT; p++)
        begin
            if (reg_addr == tpg_pkg::ADDR_FSEL[p])
                next_rdata = fsel[p];
            else if (reg_addr == tpg_pkg::ADDR_DAT[p])
                next_rdata = {dir[p], dout[p], rstlvl[p], smp[p]};
            else if (reg_addr == tpg_pkg::ADDR_PAR[p])
                next_rdata = {8'h00, lock[p], drv[p], puoff[p]};
        end
    end

    // read data stands for exactly the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= tpg_pkg::RD_ZERO;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= tpg_pkg::RD_ZERO;
    end

endmodule // tpg_gpio

`default_nettype wire

/* File: tpg_gpio_properties.sv */
`timescale 1ns/10ps
`default_nettype none

//=====
// port-level checks on the gpio top
module tpg_gpio_chk
(
    input wire logic sys_clk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic [31:0] reg_addr, // address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [31:0] reg_rdata, // read data
    input wire logic power_save, // freeze request
    input wire logic [7:0] pin_in_p0, // port 0 levels
    input wire logic [7:0] pin_in_p2, // port 2 levels
    input wire logic [7:0] pin_out_p0, // port 0 drive
    input wire logic [7:0] pin_oe_p0, // port 0 enable
    input wire logic [7:0] pullup_en_p0, // port 0 pull-ups
    input wire logic [7:0] alt_sel_p0, // port 0 alternate
    input wire logic [7:0] alt_sel_p2, // port 2 alternate
    input wire logic [7:0] alt_in_p0, // port 0 to peripherals
    input wire logic external_interrupt_in_2 // port 2 pin 0 level
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    chk_fsel_reserved: assert property ($past(reg_rd && reg_addr ==
        tpg_pkg::ADDR_FSEL[0]) |-> (reg_rdata & ~tpg_pkg::FSEL_MASK) == 32'h0)
        else $error("reserved select bits read nonzero");
    chk_alt_limits: assert property (!alt_sel_p0[7] && alt_sel_p2[7:2] == 6'h0)
        else $error("alternate on a pin without one");
    chk_pullup_forced: assert property (pullup_en_p0[2])
        else $error("forced pull-up dropped");
    chk_power_hold: assert property ($past(power_save) |->
        $stable(pin_out_p0) && $stable(pin_oe_p0))
        else $error("pins moved in power saving");
    chk_set_pin: assert property ((reg_wr && reg_addr == tpg_pkg::ADDR_SET[0])
        ##1 (!power_save && alt_sel_p0 == 8'h0) |=> ((pin_out_p0 &
        $past(reg_wdata[23:16], 2)) == $past(reg_wdata[23:16], 2)))
        else $error("set write missed a pin");
    chk_clr_pin: assert property ((reg_wr && reg_addr == tpg_pkg::ADDR_CLR[0])
        ##1 (!power_save && alt_sel_p0 == 8'h0) |=>
        ((pin_out_p0 & $past(reg_wdata[23:16], 2)) == 8'h0))
        else $error("clear write missed a pin");
    chk_dir_oe: assert property ((reg_wr && reg_addr == tpg_pkg::ADDR_DAT[0])
        ##1 (!power_save && alt_sel_p0 == 8'h0) |=>
        pin_oe_p0 == $past(reg_wdata[31:24], 2))
        else $error("direction not on drive enables");
    chk_irq_follow: assert property ($past(rst_b) && !$past(alt_sel_p2[0]) |->
        external_interrupt_in_2 == $past(pin_in_p2[0]))
        else $error("interrupt input not following pin");
    chk_alt_in: assert property ($past(rst_b) |->
        alt_in_p0 == ($past(pin_in_p0) & $past(alt_sel_p0)))
        else $error("peripheral input level wrong");
endmodule // tpg_gpio_chk

`default_nettype wire

/* File: tpg_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none

//=====
// one port's pads: design drive wins, then the board, then pull-up
module tpg_pin_model
(
    input wire logic sys_clk, // clock
    input wire logic [7:0] pin_out, // design drive level
    input wire logic [7:0] pin_oe, // design drive enable
    input wire logic [7:0] pullup_en, // pull-up on
    input wire logic [7:0] ext_val, // board drive level
    input wire logic [7:0] ext_oe, // board drive enable
    output logic [7:0] pin_in // resolved pad level
);
    logic [7:0] flt = 8'h00;
    // an undriven pad wanders, so a stuck zero never passes by luck
    always_ff @(posedge sys_clk)
        flt <= ~pin_in;
    // pad resolution
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
        | (~pin_oe & ~ext_oe & (pullup_en | flt));
endmodule // tpg_pin_model

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none

//=====
// gpio bench
module tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, power_save = 1'b0;
    logic [7:0] pin_in_p0, pin_in_p1, pin_in_p2;
    logic [7:0] pin_out_p0, pin_out_p1, pin_out_p2;
    logic [7:0] pin_oe_p0, pin_oe_p1, pin_oe_p2;
    logic [7:0] pullup_en_p0, pullup_en_p1, pullup_en_p2;
    logic [7:0] drive_strength_p0, drive_strength_p1, drive_strength_p2;
    logic [7:0] alt_out_p0 = 8'h0, alt_out_p1 = 8'h0, alt_out_p2 = 8'h0;
    logic [7:0] alt_oe_p0 = 8'h0, alt_oe_p1 = 8'h0, alt_oe_p2 = 8'h0;
    logic [7:0] alt_in_p0, alt_in_p1, alt_in_p2;
    logic [7:0] alt_sel_p0, alt_sel_p1, alt_sel_p2;
    logic external_interrupt_in_0, external_interrupt_in_1;
    logic external_interrupt_in_2, external_interrupt_in_3;
    logic external_clock_input;
    logic [7:0] ext_v [3];
    logic [7:0] ext_oe [3];
    int err_total = 0;
    int compares = 0;

    tpg_gpio dut (.*);
    tpg_pin_model u_pad0 (.sys_clk(sys_clk), .pin_out(pin_out_p0),
        .pin_oe(pin_oe_p0), .pullup_en(pullup_en_p0), .ext_val(ext_v[0]),
        .ext_oe(ext_oe[0]), .pin_in(pin_in_p0));
    tpg_pin_model u_pad1 (.sys_clk(sys_clk), .pin_out(pin_out_p1),
        .pin_oe(pin_oe_p1), .pullup_en(pullup_en_p1), .ext_val(ext_v[1]),
        .ext_oe(ext_oe[1]), .pin_in(pin_in_p1));
    tpg_pin_model u_pad2 (.sys_clk(sys_clk), .pin_out(pin_out_p2),
        .pin_oe(pin_oe_p2), .pullup_en(pullup_en_p2), .ext_val(ext_v[2]),
        .ext_oe(ext_oe[2]), .pin_in(pin_in_p2));

    initial forever #5 sys_clk = ~sys_clk;

    //=====
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe edge
    task automatic rchk(input logic [31:0] a, m, e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    //=====
    // scenarios
    task automatic t_reset();
        for (int p = 0; p < 3; p++)
        begin
            rchk(tpg_pkg::ADDR_FSEL[p], 32'hFFFFFFFF, 32'h0);
            rchk(tpg_pkg::ADDR_DAT[p], 32'hFFFFFFFF, {16'h0, ext_v[p], ext_v[p]});
        end
        chk({24'h0, pullup_en_p0 & pullup_en_p1 & pullup_en_p2}, 32'hFF);
    endtask
    // distinct output levels per port prove the ports do not share output state
    task automatic t_dirdata();
        logic [7:0] dv;
        for (int p = 0; p < 3; p++)
            wr(tpg_pkg::ADDR_DAT[p], {8'hF0, 4'(10 + p), 20'h0});
        idle(3);
        for (int p = 0; p < 3; p++)
        begin
            dv = {4'(10 + p), 4'h0};
            rchk(tpg_pkg::ADDR_DAT[p], 32'hFFFF00FF, {8'hF0, dv, 8'h0, dv | (ext_v[p] & 8'h0F)});
        end
        chk({pin_oe_p2, pin_oe_p1, pin_oe_p0, 8'h0}, 32'hF0F0F000);
        chk({8'h0, pin_out_p2, pin_out_p1, pin_out_p0}, 32'h00C0B0A0);
    endtask
    task automatic t_setclr();
        wr(tpg_pkg::ADDR_SET[0], 32'hFF0FFFFF);
        wr(tpg_pkg::ADDR_CLR[0], 32'hFF20FFFF);
        rchk(tpg_pkg::ADDR_DAT[0], 32'hFFFF0000, 32'hF08F0000);
        rchk(tpg_pkg::ADDR_SET[0], 32'hFFFFFFFF, 32'h0);
        rchk(tpg_pkg::ADDR_CLR[0], 32'hFFFFFFFF, 32'h0);
        rchk(32'hFFFF0D10, 32'hFFFFFFFF, 32'h0);
        chk({24'h0, pin_out_p0}, 32'h8F);
    endtask
    task automatic t_power();
        @(posedge sys_clk);
        power_save <= 1'b1;
        wr(tpg_pkg::ADDR_DAT[0], 32'h0F5A0000);
        idle(3);
        chk({16'h0, pin_oe_p0, pin_out_p0}, 32'h0000F08F);
        power_save <= 1'b0;
        idle(3);
        chk({16'h0, pin_oe_p0, pin_out_p0}, 32'h00000F5A);
    endtask
    // codes from 11 down to 00, so the port is plain again at the end
    task automatic t_fsel();
        logic [31:0] v;
        {alt_out_p0, alt_out_p1, alt_out_p2} <= 24'h55AA55;
        {alt_oe_p0, alt_oe_p1, alt_oe_p2} <= 24'hFFFFFF;
        for (int c = 3; c >= 0; c--)
        begin
            v = {8{2'b00, 2'(c)}};
            for (int p = 0; p < 3; p++)
                wr(tpg_pkg::ADDR_FSEL[p], v);
            idle(1);
            chk({8'h0, alt_sel_p2, alt_sel_p1, alt_sel_p0}, (c == 1) ? {8'h0, tpg_pkg::ALT_MASK[2], tpg_pkg::ALT_MASK[1], tpg_pkg::ALT_MASK[0]} : 32'h0);
            rchk(tpg_pkg::ADDR_FSEL[1], 32'hFFFFFFFF, v & 32'h03333333);
            if (c == 1)
                chk({8'h0, alt_in_p2, alt_in_p1, alt_in_p0}, 32'h00012A55);
        end
    endtask
    task automatic t_lock();
        wr(tpg_pkg::ADDR_PAR[1], 32'h000F0000);
        wr(tpg_pkg::ADDR_DAT[1], 32'hFFFF0000);
        wr(tpg_pkg::ADDR_FSEL[1], 32'h01111111);
        rchk(tpg_pkg::ADDR_DAT[1], 32'hFFFF0000, 32'hF0F00000);
        rchk(tpg_pkg::ADDR_FSEL[1], 32'hFFFFFFFF, 32'h01110000);
        wr(tpg_pkg::ADDR_PAR[1], 32'h0);
        wr(tpg_pkg::ADDR_DAT[1], 32'h0);
        wr(tpg_pkg::ADDR_FSEL[1], 32'h0);
    endtask
    task automatic t_pullup();
        wr(tpg_pkg::ADDR_PAR[0], 32'h0000A5FF);
        wr(tpg_pkg::ADDR_DAT[0], 32'h0);
        ext_oe[0] <= 8'h00;
        idle(3);
        chk({24'h0, pullup_en_p0}, 32'h04);
        chk({24'h0, drive_strength_p0}, 32'hA5);
        rchk(tpg_pkg::ADDR_DAT[0], 32'h04, 32'h04);
        wr(tpg_pkg::ADDR_PAR[0], 32'h0);
        wr(tpg_pkg::ADDR_DAT[0], 32'h0);
        idle(3);
        rchk(tpg_pkg::ADDR_DAT[0], 32'hFF, 32'hFF);
        ext_oe[0] <= 8'hFF;
    endtask
    task automatic t_irq();
        wr(tpg_pkg::ADDR_DAT[2], 32'h0);
        ext_v <= '{8'h10, 8'h01, 8'h02};
        idle(3);
        chk({27'h0, external_interrupt_in_0, external_interrupt_in_1, external_interrupt_in_2, external_interrupt_in_3, external_clock_input}, 32'h1A);
        ext_v[2] <= 8'h03;
        idle(3);
        chk({27'h0, external_interrupt_in_0, external_interrupt_in_1, external_interrupt_in_2, external_interrupt_in_3, external_clock_input}, 32'h1F);
        rchk(tpg_pkg::ADDR_DAT[0], 32'h0000FF00, 32'h00005A00);
    endtask

    //=====
    // main sequence and hang guard
    initial
    begin
        ext_v = '{8'h5A, 8'h3C, 8'hC3};
        ext_oe = '{8'hFF, 8'hFF, 8'hFF};
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_dirdata();
        t_setclr();
        t_power();
        t_fsel();
        t_lock();
        t_pullup();
        t_irq();
        end_of_test();
    end
    initial
    begin
        #500000;
        err_total++;
        end_of_test();
    end
endmodule // tb

bind tpg_gpio tpg_gpio_chk u_chk (.*);

`default_nettype wire
